// ==== verilog/return_rotate_sleep_exec.sv ====
// Execution core for the return, rotate-through-carry and sleep instructions, with an APB register window.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module return_rotate_sleep_exec #(
	parameter int PC_W = 11,
	parameter int STACK_DEPTH = 5,
	parameter logic [7:0] WDT_PRESCALE_TOP = rrs_pkg::WDT_PRESCALE_MAX
) (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// Program memory fetch.
	output logic [PC_W-1:0] o_fetch_addr,
	input wire logic [rrs_pkg::INSTR_W-1:0] i_instr,
	// File register access.
	output logic [rrs_pkg::FADDR_W-1:0] o_file_raddr,
	input wire logic [rrs_pkg::DATA_W-1:0] i_file_rdata,
	output rrs_pkg::file_wr_s o_file_wr,
	// Core state.
	output logic [rrs_pkg::DATA_W-1:0] o_working_register,
	output logic o_carry,
	output logic o_watchdog_expiry_flag_n,
	output logic o_sleep_entered_flag_n,
	output logic o_sleeping,
	output logic o_wdt_timeout,
	// APB slave.
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);
	localparam int FILL_W = $clog2(STACK_DEPTH+1);

	rrs_pkg::core_state_e state;
	rrs_pkg::instr_fields_s fld;
	logic [PC_W-1:0] pc;
	logic instr_ok, run_en, wake_req, flag_restore;
	logic [7:0] working;
	logic carry, exec;
	logic is_ret, is_retlit, is_rotl, is_rotr, is_rot, is_sleep, is_subb;
	logic [7:0] rot_result;
	logic rot_carry;
	logic [PC_W-1:0] stack_top;
	logic [FILL_W-1:0] stack_fill;
	logic stack_pop, stack_push;
	logic [7:0] wdt_count, wdt_prescale;
	logic wdt_tick, wdt_expire, sleep_clear, expiry_n, sleep_n;
	logic apb_setup, apb_wr, addr_ok;
	logic [31:0] next_prdata;

	generate
		if (PC_W < 8 || PC_W > 16) begin : g_pc_check
			$error("PC_W must lie between 8 and 16");
		end
	endgenerate

	// Field split shared by every register-operand instruction.
	assign fld = '{
		op: i_instr[rrs_pkg::OP_LSB +: rrs_pkg::OP_W],
		dest: i_instr[rrs_pkg::DEST_BIT],
		faddr: i_instr[rrs_pkg::FADDR_LSB +: rrs_pkg::FADDR_W],
		literal: i_instr[rrs_pkg::LIT_LSB +: rrs_pkg::DATA_W]
	}; // RULE7

	assign is_ret = (i_instr == rrs_pkg::OP_RETURN);
	assign is_sleep = (i_instr == rrs_pkg::OP_SLEEP);
	assign is_retlit = (i_instr[rrs_pkg::RETLIT_LSB +: rrs_pkg::RETLIT_W] == rrs_pkg::OP_RETLIT);
	assign is_rotl = (fld.op == rrs_pkg::OP_ROTL);
	assign is_rotr = (fld.op == rrs_pkg::OP_ROTR);
	assign is_subb = (fld.op == rrs_pkg::OP_SUBB);
	assign is_rot = is_rotl || is_rotr;

	// The word on i_instr is only live when fetched in the previous running or flush cycle.
	assign exec = (state == rrs_pkg::ST_RUN) && instr_ok && run_en;
	assign stack_pop = exec && (is_ret || is_retlit); // RULE2
	assign sleep_clear = exec && is_sleep;

	assign o_file_raddr = fld.faddr; // RULE7
	assign o_fetch_addr = pc;
	assign o_working_register = working;
	assign o_carry = carry;
	assign o_watchdog_expiry_flag_n = expiry_n;
	assign o_sleep_entered_flag_n = sleep_n;
	assign o_sleeping = (state == rrs_pkg::ST_SLEEP);

	rotate_carry_unit #(
		.WIDTH(rrs_pkg::DATA_W)
	) u_rotate (
		.i_src(i_file_rdata),
		.i_carry(carry),
		.i_left(is_rotl),
		.o_result(rot_result),
		.o_carry(rot_carry)
	);

	return_addr_stack #(
		.ADDR_W(PC_W),
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_push(stack_push),
		.i_push_addr(i_pwdata[PC_W-1:0]),
		.i_pop(stack_pop),
		.o_top(stack_top),
		.o_fill(stack_fill)
	);

	// Sequencing of fetch address and the flush slot behind a return.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			state <= rrs_pkg::ST_RUN;
			pc <= '0;
			instr_ok <= 1'b0;
		end else begin
			case (state)
				rrs_pkg::ST_RUN: begin
					if (!run_en) begin
						// Step back so the word in flight is fetched again on restart.
						instr_ok <= 1'b0;
						if (instr_ok) begin
							pc <= pc - 1'b1;
						end
					end else if (stack_pop) begin
						pc <= stack_top; // RULE3
						instr_ok <= 1'b0; // RULE11
						state <= rrs_pkg::ST_FLUSH; // RULE2
					end else if (sleep_clear) begin
						instr_ok <= 1'b0;
						state <= rrs_pkg::ST_SLEEP; // RULE10
					end else begin
						pc <= pc + 1'b1;
						instr_ok <= 1'b1;
					end
				end
				rrs_pkg::ST_FLUSH: begin
					pc <= pc + 1'b1; // RULE11
					instr_ok <= 1'b1;
					state <= rrs_pkg::ST_RUN;
				end
				rrs_pkg::ST_SLEEP: begin
					if (wake_req) begin
						state <= rrs_pkg::ST_RUN;
					end
				end
				default: begin
					state <= rrs_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Working register and carry; returns leave carry untouched.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			working <= rrs_pkg::WORKING_RESET;
			carry <= 1'b0;
		end else if (exec) begin
			if (is_retlit) begin
				working <= fld.literal; // RULE1
			end
			if (is_rot) begin
				carry <= rot_carry; // RULE4
				if (!fld.dest) begin
					working <= rot_result; // RULE6
				end
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_file_wr <= '0;
		end else begin
			o_file_wr <= '{we: exec && is_rot && fld.dest, addr: fld.faddr, data: rot_result}; // RULE6
		end
	end

	// Watchdog: the prescaler gives a one-cycle tick that advances the counter.
	assign wdt_tick = (wdt_prescale == WDT_PRESCALE_TOP);
	assign wdt_expire = wdt_tick && (wdt_count == rrs_pkg::WDT_COUNT_MAX);

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || sleep_clear) begin
			wdt_prescale <= 8'h00; // RULE8
		end else if (wdt_tick) begin
			wdt_prescale <= 8'h00;
		end else begin
			wdt_prescale <= wdt_prescale + 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || sleep_clear) begin
			wdt_count <= 8'h00; // RULE8
		end else if (wdt_tick) begin
			wdt_count <= wdt_count + 1'b1;
		end
	end

	// A hardware event always beats the software restore in the same cycle.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			expiry_n <= 1'b1;
			sleep_n <= 1'b1;
			o_wdt_timeout <= 1'b0;
		end else begin
			o_wdt_timeout <= wdt_expire && !sleep_clear;
			if (sleep_clear) begin
				expiry_n <= 1'b1; // RULE9
			end else if (wdt_expire) begin
				expiry_n <= 1'b0;
			end else if (flag_restore) begin
				expiry_n <= 1'b1;
			end
			if (sleep_clear) begin
				sleep_n <= 1'b0; // RULE9
			end else if (flag_restore) begin
				sleep_n <= 1'b1;
			end
		end
	end

	// APB slave: zero wait states, read data latched in the setup cycle.
	assign apb_setup = i_psel && !i_penable;
	assign apb_wr = i_psel && i_penable && i_pwrite;
	assign addr_ok = (i_paddr == rrs_pkg::ADDR_CTRL) || (i_paddr == rrs_pkg::ADDR_STATUS)
		|| (i_paddr == rrs_pkg::ADDR_PC) || (i_paddr == rrs_pkg::ADDR_STACK)
		|| (i_paddr == rrs_pkg::ADDR_WDT);
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !addr_ok;
	assign stack_push = apb_wr && (i_paddr == rrs_pkg::ADDR_STACK);

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			run_en <= rrs_pkg::CTRL_RUN_RESET;
			wake_req <= 1'b0;
			flag_restore <= 1'b0;
		end else begin
			wake_req <= 1'b0;
			flag_restore <= 1'b0;
			if (apb_wr && i_paddr == rrs_pkg::ADDR_CTRL) begin
				run_en <= i_pwdata[rrs_pkg::CTRL_RUN_BIT];
				wake_req <= i_pwdata[rrs_pkg::CTRL_WAKE_BIT];
				flag_restore <= i_pwdata[rrs_pkg::CTRL_RESTORE_BIT];
			end
		end
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (i_paddr == rrs_pkg::ADDR_CTRL) begin
			next_prdata[rrs_pkg::CTRL_RUN_BIT] = run_en;
		end else if (i_paddr == rrs_pkg::ADDR_STATUS) begin
			next_prdata[7:0] = working;
			next_prdata[rrs_pkg::ST_CARRY_BIT] = carry;
			next_prdata[rrs_pkg::ST_EXPIRY_BIT] = expiry_n;
			next_prdata[rrs_pkg::ST_SLEEPN_BIT] = sleep_n;
			next_prdata[rrs_pkg::ST_ASLEEP_BIT] = o_sleeping;
		end else if (i_paddr == rrs_pkg::ADDR_PC) begin
			next_prdata[PC_W-1:0] = pc;
		end else if (i_paddr == rrs_pkg::ADDR_STACK) begin
			next_prdata[FILL_W-1:0] = stack_fill;
		end else if (i_paddr == rrs_pkg::ADDR_WDT) begin
			next_prdata[7:0] = wdt_count;
			next_prdata[rrs_pkg::WDT_PRESCALE_LSB +: 8] = wdt_prescale;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_prdata <= 32'h0000_0000;
		end else if (apb_setup) begin
			o_prdata <= next_prdata;
		end
	end

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_return_taken;
		stack_pop;
	endsequence
	sequence s_flush_slot;
		(state == rrs_pkg::ST_FLUSH) && !exec ##1 (state == rrs_pkg::ST_RUN) && instr_ok;
	endsequence

	a_retlit_load: // RULE1
		assert property (exec && is_retlit |=> working == $past(fld.literal) && $stable(carry))
		else $error("literal return did not load the working register cleanly");
	a_return_pop_pc: // RULE2
		assert property (s_return_taken |=> pc == $past(stack_top) ##1 pc == $past(stack_top, 2) + 1'b1)
		else $error("return did not fetch from the popped address");
	a_return_no_flags: // RULE3
		assert property (exec && is_ret |=> $stable(carry) && $stable(working) && !o_file_wr.we)
		else $error("plain return changed core state");
	a_return_idle: // RULE11
		assert property (s_return_taken |=> s_flush_slot)
		else $error("return did not spend one idle cycle");

	a_rotl_result: // RULE4
		assert property (exec && is_rotl && !fld.dest |=>
			working == {$past(i_file_rdata[6:0]), $past(carry)} && carry == $past(i_file_rdata[7]))
		else $error("rotate left gave a wrong result");

	a_rotr_result: // RULE5
		assert property (exec && is_rotr && !fld.dest |=>
			working == {$past(carry), $past(i_file_rdata[7:1])} && carry == $past(i_file_rdata[0]))
		else $error("rotate right gave a wrong result");

	a_rot_to_file: // RULE6
		assert property (exec && is_rot && fld.dest |=>
			o_file_wr.we && o_file_wr.addr == $past(i_instr[5:0]) && $stable(working))
		else $error("rotate to file register went astray");

	a_subb_no_write: // RULE7
		assert property (exec && is_subb |=> !o_file_wr.we && (state == rrs_pkg::ST_RUN))
		else $error("subtract with borrow disturbed this slice");

	a_sleep_wdt_clear: // RULE8
		assert property (sleep_clear |=> wdt_count == 8'h00 && wdt_prescale == 8'h00)
		else $error("sleep did not clear the watchdog");
	a_sleep_flags: // RULE9
		assert property (sleep_clear |=> expiry_n && !sleep_n)
		else $error("sleep left wrong status flags");
	a_sleep_halt: // RULE10
		assert property (sleep_clear ##1 !wake_req |=> o_sleeping && !exec)
		else $error("core did not halt after sleep");
endmodule
`default_nettype wire

// ==== verilog/rrs_pkg.sv ====
// Shared constants, encodings and carriers for the return, rotate and sleep execution slice.
// What this block does
// RULE1 - Return-with-literal loads its 8-bit literal into the working register and changes no flag.
// RULE2 - Return-with-literal also pops the stack top into the program counter and takes two cycles.
// RULE3 - Return takes no operand, pops the stack top into the program counter, changes no flag and takes two cycles.
// RULE4 - Rotate-left puts bit 7 in carry, bits 6..0 in result 7..1 and old carry in bit 0, in one cycle.
// RULE5 - Rotate-right puts old carry in bit 7, bits 7..1 in result 6..0 and bit 0 in carry, in one cycle.
// RULE6 - A rotate with destination 0 writes the working register and with 1 writes the file register.
// RULE7 - Register-operand instructions, subtract-with-borrow among them, carry a 6-bit file address and a destination bit.
// RULE8 - Sleep clears the watchdog counter and its prescaler.
// RULE9 - Sleep sets the active-low expiry flag to 1 and clears the active-low sleep flag to 0.
// RULE10 - Sleep then halts the core in its sleep state and itself takes one cycle.
// RULE11 - A return discards the instruction fetched behind it and fetches the popped address during its one idle cycle.
`default_nettype none
package rrs_pkg;
	localparam int INSTR_W = 13;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 6;
	localparam int OP_W = 6;
	localparam int OP_LSB = 7;
	localparam int DEST_BIT = 6;
	localparam int FADDR_LSB = 0;
	localparam int LIT_LSB = 0;
	localparam int RETLIT_W = 5;
	localparam int RETLIT_LSB = 8;
	localparam logic [12:0] OP_RETURN = 13'h0003;
	localparam logic [12:0] OP_SLEEP = 13'h0004;
	localparam logic [4:0] OP_RETLIT = 5'h1a;
	localparam logic [5:0] OP_ROTL = 6'h0d;
	localparam logic [5:0] OP_ROTR = 6'h0c;
	localparam logic [5:0] OP_SUBB = 6'h0b;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PC = 8'h08;
	localparam logic [7:0] ADDR_STACK = 8'h0c;
	localparam logic [7:0] ADDR_WDT = 8'h10;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_WAKE_BIT = 1;
	localparam int CTRL_RESTORE_BIT = 2;
	localparam int ST_CARRY_BIT = 8;
	localparam int ST_EXPIRY_BIT = 9;
	localparam int ST_SLEEPN_BIT = 10;
	localparam int ST_ASLEEP_BIT = 11;
	localparam int WDT_PRESCALE_LSB = 8;
	localparam logic CTRL_RUN_RESET = 1'b0;
	localparam logic [7:0] WORKING_RESET = 8'h00;
	localparam logic [7:0] WDT_COUNT_MAX = 8'hff;
	localparam logic [7:0] WDT_PRESCALE_MAX = 8'hff;
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_FLUSH = 3'b010,
		ST_SLEEP = 3'b100
	} core_state_e;
	typedef struct packed {
		logic [OP_W-1:0] op;
		logic dest;
		logic [FADDR_W-1:0] faddr;
		logic [DATA_W-1:0] literal;
	} instr_fields_s;
	typedef struct packed {
		logic we;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} file_wr_s;
endpackage
`default_nettype wire

// ==== verilog/rotate_carry_unit.sv ====
// Rotate through carry, left or right, for one data word.
`timescale 1ns/1ps
`default_nettype none
module rotate_carry_unit #(
	parameter int WIDTH = 8
) (
	// Operands.
	input wire logic [WIDTH-1:0] i_src,
	input wire logic i_carry,
	input wire logic i_left,
	// Results.
	output logic [WIDTH-1:0] o_result,
	output logic o_carry
);
	generate
		if (WIDTH < 2) begin : g_width_check
			$error("rotate_carry_unit needs at least two bits");
		end
	endgenerate

	always_comb begin
		if (i_left) begin
			o_result = {i_src[WIDTH-2:0], i_carry}; // RULE4
			o_carry = i_src[WIDTH-1]; // RULE4
		end else begin
			o_result = {i_carry, i_src[WIDTH-1:1]}; // RULE5
			o_carry = i_src[0]; // RULE5
		end
	end
endmodule
`default_nettype wire

// ==== verilog/return_addr_stack.sv ====
// Circular hardware stack of return addresses.
`timescale 1ns/1ps
`default_nettype none
module return_addr_stack #(
	parameter int ADDR_W = 11,
	parameter int DEPTH = 5
) (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// Push and pop.
	input wire logic i_push,
	input wire logic [ADDR_W-1:0] i_push_addr,
	input wire logic i_pop,
	// Stack state.
	output logic [ADDR_W-1:0] o_top,
	output logic [$clog2(DEPTH+1)-1:0] o_fill
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int FILL_W = $clog2(DEPTH+1);

	logic [ADDR_W-1:0] mem [DEPTH];
	logic [PTR_W-1:0] ptr;
	logic [PTR_W-1:0] ptr_inc;
	logic [PTR_W-1:0] ptr_dec;

	generate
		if (DEPTH < 2) begin : g_depth_check
			$error("return_addr_stack needs at least two entries");
		end
	endgenerate

	// Overflow wraps and overwrites the oldest entry, as a small fixed stack does.
	assign ptr_inc = (ptr == PTR_W'(DEPTH-1)) ? '0 : ptr + 1'b1;
	assign ptr_dec = (ptr == '0) ? PTR_W'(DEPTH-1) : ptr - 1'b1;
	assign o_top = mem[ptr_dec];

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ptr <= '0;
		end else if (i_push && !i_pop) begin
			ptr <= ptr_inc;
		end else if (i_pop && !i_push) begin
			ptr <= ptr_dec;
		end
	end

	// A push in the same cycle as a pop replaces the top entry.
	always_ff @(posedge i_mclk) begin
		if (i_push) begin
			mem[i_pop ? ptr_dec : ptr] <= i_push_addr;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_fill <= '0;
		end else if (i_push && !i_pop && o_fill != FILL_W'(DEPTH)) begin
			o_fill <= o_fill + 1'b1;
		end else if (i_pop && !i_push && o_fill != '0) begin
			o_fill <= o_fill - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking testbench for the return, rotate and sleep execution core.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [7:0] TOP = 8'h03;
	localparam int WDT_PERIOD = (TOP + 1) * 256;
	logic i_mclk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [12:0] i_instr = 13'h0000;
	logic [7:0] i_file_rdata;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0;
	logic [10:0] o_fetch_addr;
	logic [5:0] o_file_raddr;
	rrs_pkg::file_wr_s o_file_wr;
	logic [7:0] o_working_register;
	logic o_carry;
	logic o_watchdog_expiry_flag_n;
	logic o_sleep_entered_flag_n;
	logic o_sleeping;
	logic o_wdt_timeout;
	logic [31:0] o_prdata;
	logic o_pready;
	logic o_pslverr;
	logic [12:0] mem [0:2047];
	logic [7:0] freg [0:63];
	logic [7:0] lit;
	logic was_sl = 1'b0;
	logic [13:0] wq [$];
	logic [13:0] eq [$];
	int wt [$];
	int cyc = 0;
	int t_sleep = 0;
	int t_wdt = 0;
	int n_fail = 0;
	int cmp_count = 0;

	return_rotate_sleep_exec #(.PC_W(11), .STACK_DEPTH(5), .WDT_PRESCALE_TOP(TOP)) uut (
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .o_fetch_addr(o_fetch_addr), .i_instr(i_instr),
		.o_file_raddr(o_file_raddr), .i_file_rdata(i_file_rdata), .o_file_wr(o_file_wr),
		.o_working_register(o_working_register), .o_carry(o_carry),
		.o_watchdog_expiry_flag_n(o_watchdog_expiry_flag_n), .o_sleep_entered_flag_n(o_sleep_entered_flag_n),
		.o_sleeping(o_sleeping), .o_wdt_timeout(o_wdt_timeout), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr));

	initial begin
		forever #5 i_mclk = ~i_mclk;
	end

	// Program memory answers one cycle late, like the synchronous ROM the core expects.
	always @(posedge i_mclk) begin
		i_instr <= mem[o_fetch_addr];
	end

	always_comb begin
		i_file_rdata = freg[o_file_raddr];
	end

	always @(posedge i_mclk) begin
		cyc = cyc + 1;
		if (o_file_wr.we === 1'b1) begin
			wq.push_back({o_file_wr.addr, o_file_wr.data});
			wt.push_back(cyc);
		end
		if (o_sleeping === 1'b1 && was_sl !== 1'b1) begin
			t_sleep = cyc;
		end
		was_sl = o_sleeping;
		if (o_wdt_timeout === 1'b1) begin
			t_wdt = cyc;
		end
	end

	function automatic logic [12:0] rop(input logic [5:0] op, input logic d, input logic [5:0] f);
		return {op, d, f};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Entered just after a rising edge; leaves one idle cycle so psel is never assigned twice in a step.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			complete_run();
		end
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_mclk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, 32'h0, d, e);
		check(d, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	// Waits for sleep (which 0) or a watchdog pulse (which 1); a wait that runs out ends the run.
	task automatic wait_for(input int which, input int lim);
		int n;
		n = 0;
		while (n < lim && !((which == 0) ? (o_sleeping === 1'b1) : (o_wdt_timeout === 1'b1))) begin
			@(posedge i_mclk);
			n++;
		end
		if (n >= lim) begin
			n_fail++;
			complete_run();
		end
	endtask

	task automatic do_reset();
		i_sys_rst <= 1'b1;
		repeat (5) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		@(posedge i_mclk);
		for (int i = 0; i < 2048; i++) mem[i] = 13'h0000;
		wq.delete();
		wt.delete();
	endtask

	initial begin
		logic [31:0] d;
		logic e;
		void'($urandom(20972));
		for (int i = 0; i < 64; i++) freg[i] = $urandom;
		lit = $urandom;
		do_reset();
		rd_chk(rrs_pkg::ADDR_STATUS, 32'h0000_0600);
		rd_chk(rrs_pkg::ADDR_CTRL, 32'h0);
		wr(rrs_pkg::ADDR_STATUS, 32'hffff_ffff);
		rd_chk(rrs_pkg::ADDR_STATUS, 32'h0000_0600);
		apb(1'b0, 8'h14, 32'h0, d, e);
		check(d, 32'h0);
		check({31'h0, e}, 32'h1);
		$display("test registers done");
		// A watchdog expiry first, so that sleep has a cleared flag to set again.
		wait_for(1, 1200);
		rd_chk(rrs_pkg::ADDR_STATUS, 32'h0000_0400);
		mem[0] = rop(rrs_pkg::OP_ROTL, 1'b1, 6'd5);
		mem[1] = {rrs_pkg::OP_RETLIT, lit};
		mem[2] = rop(rrs_pkg::OP_ROTL, 1'b1, 6'd7);
		mem[10] = rop(rrs_pkg::OP_ROTR, 1'b1, 6'd6);
		mem[11] = rop(rrs_pkg::OP_SUBB, 1'b1, 6'd7);
		mem[12] = rrs_pkg::OP_RETURN;
		mem[13] = rop(rrs_pkg::OP_ROTL, 1'b1, 6'd7);
		mem[30] = rrs_pkg::OP_SLEEP;
		mem[31] = rop(rrs_pkg::OP_ROTL, 1'b1, 6'd7);
		eq.push_back({6'd5, freg[5][6:0], 1'b0});
		eq.push_back({6'd6, freg[5][7], freg[6][7:1]});
		wr(rrs_pkg::ADDR_STACK, 32'd30);
		wr(rrs_pkg::ADDR_STACK, 32'd10);
		rd_chk(rrs_pkg::ADDR_STACK, 32'd2);
		wr(rrs_pkg::ADDR_CTRL, 32'h1);
		wait_for(0, 100);
		rd_chk(rrs_pkg::ADDR_STATUS, {20'h0, 1'b1, 1'b0, 1'b1, freg[6][0], lit});
		rd_chk(rrs_pkg::ADDR_PC, 32'd31);
		check({24'h0, o_working_register}, {24'h0, lit});
		check({30'h0, o_watchdog_expiry_flag_n, o_sleep_entered_flag_n}, 32'h2);
		check({30'h0, o_carry, o_sleeping}, {30'h0, freg[6][0], 1'b1});
		check({26'h0, o_file_raddr}, 32'd7);
		check(wq.size(), 32'd2);
		for (int i = 0; i < 2 && i < wq.size(); i++) check({18'h0, wq[i]}, {18'h0, eq[i]});
		if (wq.size() == 2) begin
			check(wt[1] - wt[0], 32'd3);
			check(t_sleep - wt[1], 32'd4);
		end
		$display("test program done");
		wait_for(1, 1200);
		rd_chk(rrs_pkg::ADDR_CTRL, 32'h1);
		check((t_wdt - t_sleep >= WDT_PERIOD - 2 && t_wdt - t_sleep <= WDT_PERIOD + 2), 32'h1);
		wr(rrs_pkg::ADDR_CTRL, 32'h5);
		rd_chk(rrs_pkg::ADDR_STATUS, {20'h0, 1'b1, 1'b1, 1'b1, freg[6][0], lit});
		wr(rrs_pkg::ADDR_CTRL, 32'h3);
		rd_chk(rrs_pkg::ADDR_STATUS, {20'h0, 1'b0, 1'b1, 1'b1, freg[6][0], lit});
		$display("test watchdog done");
		do_reset();
		mem[0] = rop(rrs_pkg::OP_ROTL, 1'b0, 6'd5);
		mem[2] = rop(rrs_pkg::OP_ROTR, 1'b1, 6'd6);
		mem[3] = rrs_pkg::OP_SLEEP;
		mem[4] = rop(rrs_pkg::OP_ROTL, 1'b1, 6'd7);
		eq.delete();
		eq.push_back({6'd6, freg[5][7], freg[6][7:1]});
		wr(rrs_pkg::ADDR_CTRL, 32'h1);
		// A pause while a word is in flight must neither lose nor repeat that word.
		wr(rrs_pkg::ADDR_CTRL, 32'h0);
		wr(rrs_pkg::ADDR_CTRL, 32'h1);
		wait_for(0, 100);
		rd_chk(rrs_pkg::ADDR_STATUS, {20'h0, 1'b1, 1'b0, 1'b1, freg[6][0], freg[5][6:0], 1'b0});
		rd_chk(rrs_pkg::ADDR_PC, 32'd4);
		check({21'h0, o_fetch_addr}, 32'd4);
		check(wq.size(), 32'd1);
		if (wq.size() == 1) begin
			check({18'h0, wq[0]}, {18'h0, eq[0]});
		end
		$display("test working destination done");
		complete_run();
	end
endmodule
`default_nettype wire
